// ---- hdl/timeslot_cpu_access_sync_transfer.sv ----
// Purpose: Processor channels on the configurable interface and a
//          two-channel frame-synchronous transfer unit
// Assumes: Serial sides are presented per timeslot byte on clk
// Notes: Avalon-MM slave, one answer per request, fixed latency
// Behaviour
// - Downstream processor channel sends stored byte each frame
// - Upstream processor channel refreshes stored byte each frame
// - Command 48 writes data field only
// - Command C8 reads data field, busy gates result
// - Command F0 returns code in low nibble
// - Command 70 writes code 0000, data ignored
// - Two independent transfer channels A and B
// - Copy data register to destination, then source to data register
// - Addresses pick interface/slot; control enables, subslots
// - Transfer write overwrites any stored idle code
// - PCM exchange of 8, 4 or 2 bits
// - Configurable interface uses full byte via control memory
// - Window-open flag raised when host window opens
// - Overflow flag if enabled register not accessed
// - Unwritten data register retransmits received value
// - Flags raised at fixed frame points
// - Transfer repeats once per 125 us frame
// - Window closed at most 16 periods per channel plus 1
// - Reading interrupt status clears both flags
// - Channel type code selects transferred bits
// - Bit 7 first on serial side, bit 0 last
//
// The Avalon-MM interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "xfer_consts.svh"

module timeslot_cpu_access_sync_transfer
    import xfer_pkg::*;
#(
    parameter int SLOTS = 128
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic frame_sync,
    input wire logic pcm_rx_valid,
    input wire logic [6:0] pcm_rx_addr,
    input wire logic [7:0] pcm_rx_data,
    input wire logic [6:0] pcm_tx_addr,
    output logic [7:0] pcm_tx_data,
    input wire logic cfi_rx_valid,
    input wire logic [6:0] cfi_rx_addr,
    input wire logic [7:0] cfi_rx_data,
    input wire logic [6:0] cfi_tx_addr,
    output logic [7:0] cfi_tx_data,
    output logic cfi_tx_valid
);

    function automatic logic [7:0] type_mask(input logic [2:0] ct);
        logic [7:0] m;
        m = 8'h00;
        case (ct)
            3'b001: m = 8'hFF;
            3'b010: m = 8'h0F;
            3'b011: m = 8'hF0;
            3'b100: m = 8'h03;
            3'b101: m = 8'h0C;
            3'b110: m = 8'h30;
            3'b111: m = 8'hC0;
            default: m = 8'h00;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] merge(input logic [7:0] old_b,
        input logic [7:0] new_b, input logic [7:0] m);
        return (old_b & ~m) | (new_b & m);
    endfunction

    // Memories: data memory per direction, control memory fields
    logic [7:0] dm_down [SLOTS];
    logic [7:0] dm_up [SLOTS];
    logic [7:0] cm_data [SLOTS];
    logic [3:0] cm_code [SLOTS];

    logic [7:0] xfer_data_a;
    logic [7:0] xfer_data_b;
    xfer_addr_s xfer_rx_addr_a;
    xfer_addr_s xfer_rx_addr_b;
    xfer_addr_s xfer_tx_addr_a;
    xfer_addr_s xfer_tx_addr_b;
    xfer_ctrl_s xfer_control;
    logic window_open_irq;
    logic window_overflow_irq;
    logic [7:0] mem_access_data;
    logic [7:0] mem_access_addr;
    logic [7:0] mem_access_cmd;
    logic mem_access_busy;
    logic acc_a;
    logic acc_b;
    logic chan_b;
    logic [11:0] closed_cnt;
    xfer_state_e state;
    xfer_state_e next_state;
    logic [2:0] fs_sync;
    logic fs_level;

    // Frame pin: three stages, rise counted when last two agree
    wire fs_agree = fs_sync[1] == fs_sync[2];
    wire frame_edge = fs_agree & fs_sync[2] & ~fs_level;

    // Bus decode
    wire [3:0] word = address[5:2];
    wire wr_fire = write & ~waitrequest & byteenable[0];
    wire rd_fire = read & ~waitrequest;
    wire window_open = state == ST_OPEN;
    wire hit_a = word == `IDX_DATA_A;
    wire hit_b = word == `IDX_DATA_B;
    wire host_wr_a = wr_fire & hit_a & window_open;
    wire host_wr_b = wr_fire & hit_b & window_open;
    wire touch_a = (wr_fire | rd_fire) & hit_a & window_open;
    wire touch_b = (wr_fire | rd_fire) & hit_b & window_open;
    wire irq_rd = rd_fire & (word == `IDX_IRQ);
    wire [7:0] wbyte = writedata[7:0];

    wire [7:0] status_byte = {6'h00, window_open, mem_access_busy};
    wire [7:0] irq_byte = {6'h00, window_open_irq, window_overflow_irq};
    wire [7:0] rd_value =
        (word == `IDX_DATA_A) ? xfer_data_a :
        (word == `IDX_DATA_B) ? xfer_data_b :
        (word == `IDX_RX_A) ? xfer_rx_addr_a :
        (word == `IDX_RX_B) ? xfer_rx_addr_b :
        (word == `IDX_TX_A) ? xfer_tx_addr_a :
        (word == `IDX_TX_B) ? xfer_tx_addr_b :
        (word == `IDX_CTRL) ? xfer_control :
        (word == `IDX_IRQ) ? irq_byte :
        (word == `IDX_MA_DATA) ? mem_access_data :
        (word == `IDX_MA_ADDR) ? mem_access_addr :
        (word == `IDX_MA_CMD) ? mem_access_cmd :
        (word == `IDX_STATUS) ? status_byte : `RST_BYTE;

    // Current transfer channel selection
    wire en_a = xfer_control.en_a;
    wire en_b = xfer_control.en_b;
    wire any_en = en_a | en_b;
    xfer_addr_s cur_rx;
    xfer_addr_s cur_tx;
    assign cur_rx = chan_b ? xfer_rx_addr_b : xfer_rx_addr_a;
    assign cur_tx = chan_b ? xfer_tx_addr_b : xfer_tx_addr_a;
    wire [2:0] cur_type = chan_b ? xfer_control.type_b
                                 : xfer_control.type_a;
    wire [7:0] cur_data = chan_b ? xfer_data_b : xfer_data_a;
    // Sub-timeslots only on PCM; the other interface moves whole bytes
    wire [7:0] rx_mask = cur_rx.configurable_interface ? 8'hFF : type_mask(cur_type);
    wire [7:0] tx_mask = cur_tx.configurable_interface ? 8'hFF : type_mask(cur_type);
    wire [7:0] src_byte = cur_rx.configurable_interface ? cm_data[cur_rx.slot]
                                     : dm_down[cur_rx.slot];
    wire [7:0] dst_old = cur_tx.configurable_interface ? cm_data[cur_tx.slot]
                                    : dm_up[cur_tx.slot];
    wire [7:0] rx_merged = merge(cur_data, src_byte, rx_mask);
    wire [7:0] tx_merged = merge(dst_old, cur_data, tx_mask);
    wire tx_is_uchan = cm_code[cur_tx.slot] == `CM_CODE_UCHAN;
    wire in_rx = state == ST_RX;
    wire xfer_wr_cm = (state == ST_TX) & cur_tx.configurable_interface & tx_is_uchan;
    wire xfer_wr_dm = (state == ST_TX) & ~cur_tx.configurable_interface;

    // Control memory port: transfer, then line capture, then commands
    wire cfi_rx_uchan = cm_code[cfi_rx_addr] == `CM_CODE_UCHAN;
    wire cfi_rx_wr = cfi_rx_valid & cfi_rx_uchan & ~xfer_wr_cm;
    wire ma_go = mem_access_busy & ~xfer_wr_cm & ~cfi_rx_wr;
    wire [6:0] ma_slot = mem_access_addr[6:0];
    wire ma_is_uchan = cm_code[ma_slot] == `CM_CODE_UCHAN;
    wire ma_set = ma_go & (mem_access_cmd == `CMD_SET_UCHAN);
    wire ma_wr = ma_go & (mem_access_cmd == `CMD_WR_DATA) & ma_is_uchan;
    wire ma_rdd = ma_go & (mem_access_cmd == `CMD_RD_DATA);
    wire ma_rdc = ma_go & (mem_access_cmd == `CMD_RD_CODE);
    wire ma_cancel = ma_go & (mem_access_cmd == `CMD_CANCEL);

    // Closed window length in clock cycles
    wire [1:0] n_en = {1'b0, en_a} + {1'b0, en_b};
    wire [11:0] closed_len = 12'((`CLOSED_RCL_PER_CHAN * n_en
        + `CLOSED_RCL_EXTRA) * `RCL_CYC);
    wire closed_done = closed_cnt >= closed_len - 12'h001;
    wire set_sov = (state == ST_CHECK)
        & ((en_a & ~acc_a) | (en_b & ~acc_b));
    wire set_sin = (state == ST_CLOSED) & closed_done;

    always_comb
    begin
        next_state = state;
        case (state)
            ST_OPEN:
                if (frame_edge & any_en)
                    next_state = ST_CHECK;
            // Send before capture, so a host write reaches the line
            ST_CHECK: next_state = ST_TX;
            ST_TX: next_state = ST_RX;
            ST_RX:
                if (~chan_b & en_b)
                    next_state = ST_TX;
                else
                    next_state = ST_CLOSED;
            ST_CLOSED:
                if (closed_done)
                    next_state = ST_OPEN;
            default: next_state = ST_OPEN;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fs_sync <= 3'h0;
            fs_level <= 1'b0;
        end
        else
        begin
            fs_sync <= {fs_sync[1:0], frame_sync};
            fs_level <= fs_agree ? fs_sync[2] : fs_level;
        end
    end

    // Bus answer one cycle after the request is seen
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end
        else
        begin
            waitrequest <= ~((read | write) & waitrequest);
            readdata <= {24'h000000, rd_value};
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_OPEN;
            chan_b <= 1'b0;
            closed_cnt <= 12'h000;
        end
        else
        begin
            state <= next_state;
            closed_cnt <= window_open ? 12'h000 : closed_cnt + 12'h001;
            if (state == ST_CHECK)
                chan_b <= ~en_a;
            else if (state == ST_RX & ~chan_b)
                chan_b <= 1'b1;
        end
    end

    // Flags: a set in the same cycle as the reading clear wins
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            window_open_irq <= 1'b0;
            window_overflow_irq <= 1'b0;
            acc_a <= 1'b0;
            acc_b <= 1'b0;
        end
        else
        begin
            window_open_irq <= set_sin
                | (window_open_irq & ~irq_rd);
            window_overflow_irq <= set_sov
                | (window_overflow_irq & ~irq_rd);
            acc_a <= ~set_sin & (acc_a | touch_a);
            acc_b <= ~set_sin & (acc_b | touch_b);
        end
    end

    // Software registers; data registers only open to the host
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_rx_addr_a <= `RST_BYTE;
            xfer_rx_addr_b <= `RST_BYTE;
            xfer_tx_addr_a <= `RST_BYTE;
            xfer_tx_addr_b <= `RST_BYTE;
            xfer_control <= `RST_BYTE;
            mem_access_addr <= `RST_BYTE;
            mem_access_cmd <= `RST_BYTE;
        end
        else if (wr_fire)
        begin
            case (word)
                `IDX_RX_A: xfer_rx_addr_a <= wbyte;
                `IDX_RX_B: xfer_rx_addr_b <= wbyte;
                `IDX_TX_A: xfer_tx_addr_a <= wbyte;
                `IDX_TX_B: xfer_tx_addr_b <= wbyte;
                `IDX_CTRL: xfer_control <= wbyte;
                `IDX_MA_ADDR: mem_access_addr <= wbyte;
                `IDX_MA_CMD: mem_access_cmd <= wbyte;
                default: xfer_control <= xfer_control;
            endcase
        end
    end

    // Bit 7 of each data register is the first bit on the line
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            xfer_data_a <= `RST_BYTE;
            xfer_data_b <= `RST_BYTE;
        end
        else
        begin
            if (in_rx & ~chan_b)
                xfer_data_a <= rx_merged;
            else if (host_wr_a)
                xfer_data_a <= wbyte;
            if (in_rx & chan_b)
                xfer_data_b <= rx_merged;
            else if (host_wr_b)
                xfer_data_b <= wbyte;
        end
    end

    // Memory-access commands; busy stays up until the port is free
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mem_access_busy <= 1'b0;
            mem_access_data <= `RST_BYTE;
        end
        else
        begin
            if (wr_fire & (word == `IDX_MA_CMD))
                mem_access_busy <= 1'b1;
            else if (ma_go)
                mem_access_busy <= 1'b0;
            if (ma_rdd)
                mem_access_data <= cm_data[ma_slot];
            else if (ma_rdc)
                mem_access_data <= {4'h0, cm_code[ma_slot]};
            else if (wr_fire & (word == `IDX_MA_DATA) & ~mem_access_busy)
                mem_access_data <= wbyte;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < SLOTS; i++)
                cm_code[i] <= `CM_CODE_FREE;
        end
        else if (ma_set)
            cm_code[ma_slot] <= `CM_CODE_UCHAN;
        else if (ma_cancel)
            cm_code[ma_slot] <= `CM_CODE_FREE;
    end

    // Only the transfer unit writes the upstream data memory
    always_ff @(posedge clk)
    begin
        if (pcm_rx_valid)
            dm_down[pcm_rx_addr] <= pcm_rx_data;
        if (xfer_wr_dm)
            dm_up[cur_tx.slot] <= tx_merged;
        if (xfer_wr_cm)
            cm_data[cur_tx.slot] <= tx_merged;
        else if (cfi_rx_wr)
            cm_data[cfi_rx_addr] <= cfi_rx_data;
        else if (ma_set | ma_wr)
            cm_data[ma_slot] <= mem_access_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pcm_tx_data <= `RST_BYTE;
            cfi_tx_data <= `RST_BYTE;
            cfi_tx_valid <= 1'b0;
        end
        else
        begin
            pcm_tx_data <= dm_up[pcm_tx_addr];
            cfi_tx_data <= cm_data[cfi_tx_addr];
            cfi_tx_valid <= cm_code[cfi_tx_addr] == `CM_CODE_UCHAN;
        end
    end

    wire [7:0] cfi_tx_cur = cm_data[cfi_tx_addr];
    wire cfi_tx_ok = cm_code[cfi_tx_addr] == `CM_CODE_UCHAN;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    cfi_idle_send_a: assert property (cfi_tx_ok |=> cfi_tx_valid
        && cfi_tx_data == $past(cfi_tx_cur))
        else $error("idle byte not sent");
    cfi_capture_a: assert property (cfi_rx_wr |=>
        cm_data[$past(cfi_rx_addr)] == $past(cfi_rx_data))
        else $error("upstream byte not stored");
    code_read_a: assert property (ma_rdc |=> !mem_access_busy
        && mem_access_data == {4'h0, $past(cm_code[ma_slot])})
        else $error("code readback wrong");
    cancel_code_a: assert property (ma_cancel |=>
        cm_code[$past(ma_slot)] == `CM_CODE_FREE)
        else $error("cancel did not free slot");
    pcm_dest_a: assert property (xfer_wr_dm |=>
        (dm_up[$past(cur_tx.slot)] & $past(tx_mask))
        == ($past(cur_data) & $past(tx_mask)))
        else $error("transfer write wrong");
    overflow_flag_a: assert property (set_sov |=> window_overflow_irq
        ##1 (window_overflow_irq || $past(irq_rd)))
        else $error("overflow flag lost");
    closed_bound_a: assert property (!window_open |->
        closed_cnt < closed_len)
        else $error("window closed too long");
    open_flag_a: assert property ($rose(window_open) |->
        window_open_irq && !acc_a && !acc_b)
        else $error("window open flag missing");
    irq_clear_a: assert property (irq_rd && !set_sin && !set_sov |=>
        !window_open_irq && !window_overflow_irq)
        else $error("read did not clear flags");
    frame_start_a: assert property (frame_edge && window_open && any_en
        |=> state == ST_CHECK ##1 state == ST_TX)
        else $error("frame did not start transfer");

    sov_seen_c: cover property (set_sov);
    sin_seen_c: cover property (set_sin ##[1:100] irq_rd);
    chan_b_c: cover property (state == ST_RX && chan_b && en_a);
    cmd_read_c: cover property (ma_rdd);

endmodule

// ---- hdl/xfer_consts.svh ----
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 250 MHz core clock, byte-wide registers on 32-bit words
// Notes: Receive clock period taken as 244 ns (4096 kHz line clock)
`ifndef XFER_CONSTS_SVH
`define XFER_CONSTS_SVH

// Register word indices; byte address is four times the index
`define IDX_DATA_A 4'h0
`define IDX_DATA_B 4'h1
`define IDX_RX_A 4'h2
`define IDX_RX_B 4'h3
`define IDX_TX_A 4'h4
`define IDX_TX_B 4'h5
`define IDX_CTRL 4'h6
`define IDX_IRQ 4'h7
`define IDX_MA_DATA 4'h8
`define IDX_MA_ADDR 4'h9
`define IDX_MA_CMD 4'hA
`define IDX_STATUS 4'hB

// Status bit positions
`define BIT_OPEN_IRQ 1
`define BIT_OVF_IRQ 0
`define BIT_MA_BUSY 0
`define BIT_WIN_OPEN 1

`define RST_BYTE 8'h00

// Control memory codes and memory-access commands
`define CM_CODE_UCHAN 4'h9
`define CM_CODE_FREE 4'h0
`define CMD_SET_UCHAN 8'h79
`define CMD_WR_DATA 8'h48
`define CMD_RD_DATA 8'hC8
`define CMD_RD_CODE 8'hF0
`define CMD_CANCEL 8'h70

// Timing
`define CLK_PERIOD_NS 4
`define RCL_PERIOD_NS 244
`define RCL_CYC (`RCL_PERIOD_NS / `CLK_PERIOD_NS)
`define CLOSED_RCL_PER_CHAN 16
`define CLOSED_RCL_EXTRA 1
`define CT_FULL 3'b001

`endif

// ---- hdl/xfer_pkg.sv ----
// Purpose: Types shared by the timeslot transfer block
// Assumes: 128 timeslot addresses per interface
// Notes: Constants live in xfer_consts.svh
package xfer_pkg;

    typedef enum logic [2:0] {
        ST_OPEN = 3'b000,
        ST_CHECK = 3'b001,
        ST_RX = 3'b010,
        ST_TX = 3'b011,
        ST_CLOSED = 3'b100
    } xfer_state_e;

    // Interface select plus port/timeslot address
    typedef struct packed {
        logic configurable_interface;
        logic [6:0] slot;
    } xfer_addr_s;

    typedef struct packed {
        logic en_b;
        logic en_a;
        logic [2:0] type_b;
        logic [2:0] type_a;
    } xfer_ctrl_s;

endpackage

// ---- verif/line_side_model.sv ----
// Purpose: Serial line side of the block: PCM and configurable bytes
// Assumes: One byte per timeslot strobe, frame pin driven from here
// Notes: Released data lines show the inverse of the last byte
`timescale 1ns/1ps
module line_side_model
(
    input wire logic clk,
    output logic frame_sync,
    output logic pcm_rx_valid,
    output logic [6:0] pcm_rx_addr,
    output logic [7:0] pcm_rx_data,
    output logic [6:0] pcm_tx_addr,
    input wire logic [7:0] pcm_tx_data,
    output logic cfi_rx_valid,
    output logic [6:0] cfi_rx_addr,
    output logic [7:0] cfi_rx_data,
    output logic [6:0] cfi_tx_addr,
    input wire logic [7:0] cfi_tx_data,
    input wire logic cfi_tx_valid
);
    initial
    begin
        frame_sync = 1'b0;
        pcm_rx_valid = 1'b0;
        pcm_rx_addr = 7'h00;
        pcm_rx_data = 8'h00;
        pcm_tx_addr = 7'h00;
        cfi_rx_valid = 1'b0;
        cfi_rx_addr = 7'h00;
        cfi_rx_data = 8'h00;
        cfi_tx_addr = 7'h00;
    end

    // Whole byte, bit 7 is the first on the wire
    task automatic put(input logic configurable_interface, input logic [6:0] a,
        input logic [7:0] d);
        @(posedge clk);
        pcm_rx_addr <= a;
        cfi_rx_addr <= a;
        pcm_rx_data <= d;
        cfi_rx_data <= d;
        pcm_rx_valid <= ~configurable_interface;
        cfi_rx_valid <= configurable_interface;
        @(posedge clk);
        pcm_rx_valid <= 1'b0;
        cfi_rx_valid <= 1'b0;
        pcm_rx_data <= ~d;
        cfi_rx_data <= ~d;
    endtask

    task automatic peek(input logic configurable_interface, input logic [6:0] a,
        output logic [7:0] d, output logic v);
        @(posedge clk);
        pcm_tx_addr <= a;
        cfi_tx_addr <= a;
        repeat (2) @(posedge clk);
        #1;
        d = configurable_interface ? cfi_tx_data : pcm_tx_data;
        v = cfi_tx_valid;
    endtask

    // One pulse starts one frame
    task automatic frame();
        @(posedge clk);
        frame_sync <= 1'b1;
        repeat (8) @(posedge clk);
        frame_sync <= 1'b0;
    endtask
endmodule

// ---- verif/tb.sv ----
// Purpose: Self-checking bench for the timeslot transfer block
// Assumes: Avalon master tasks, line side from line_side_model
// Notes: Frames are pulsed far closer than 125 us to keep runs short
`timescale 1ns/1ps
`include "xfer_consts.svh"
module tb;
    logic clk, rst_n, read, write, waitrequest;
    logic [5:0] address;
    logic [31:0] writedata, readdata;
    logic [3:0] byteenable;
    logic frame_sync, pcm_rx_valid, cfi_rx_valid, cfi_tx_valid;
    logic [6:0] pcm_rx_addr, pcm_tx_addr, cfi_rx_addr, cfi_tx_addr;
    logic [7:0] pcm_rx_data, pcm_tx_data, cfi_rx_data, cfi_tx_data;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int t0 = 0;

    timeslot_cpu_access_sync_transfer u_timeslot_cpu_access_sync_transfer
    (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .frame_sync(frame_sync), .pcm_rx_valid(pcm_rx_valid),
        .pcm_rx_addr(pcm_rx_addr), .pcm_rx_data(pcm_rx_data),
        .pcm_tx_addr(pcm_tx_addr), .pcm_tx_data(pcm_tx_data),
        .cfi_rx_valid(cfi_rx_valid), .cfi_rx_addr(cfi_rx_addr),
        .cfi_rx_data(cfi_rx_data), .cfi_tx_addr(cfi_tx_addr),
        .cfi_tx_data(cfi_tx_data), .cfi_tx_valid(cfi_tx_valid)
    );

    line_side_model u_line_side_model
    (
        .clk(clk), .frame_sync(frame_sync),
        .pcm_rx_valid(pcm_rx_valid), .pcm_rx_addr(pcm_rx_addr),
        .pcm_rx_data(pcm_rx_data), .pcm_tx_addr(pcm_tx_addr),
        .pcm_tx_data(pcm_tx_data), .cfi_rx_valid(cfi_rx_valid),
        .cfi_rx_addr(cfi_rx_addr), .cfi_rx_data(cfi_rx_data),
        .cfi_tx_addr(cfi_tx_addr), .cfi_tx_data(cfi_tx_data),
        .cfi_tx_valid(cfi_tx_valid)
    );

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) cyc <= cyc + 1;
    always @(posedge frame_sync) t0 = cyc;

    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic hang();
        error_cnt++;
        $display("Timeout at %0t", $time);
        complete_run();
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [3:0] idx,
        input logic [7:0] wd, output logic [7:0] rd);
        int n;
        @(posedge clk);
        address <= {idx, 2'h0};
        read <= ~wr;
        write <= wr;
        writedata <= {24'h000000, wd};
        for (n = 0; n < 64; n++)
        begin
            @(posedge clk);
            if (waitrequest === 1'b0)
                break;
        end
        if (n == 64)
            hang();
        rd = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, idx, d, x);
    endtask

    task automatic rdr(input logic [3:0] idx, output logic [7:0] d);
        bus(1'b0, idx, 8'h00, d);
    endtask

    task automatic mem_cmd(input logic [7:0] cmd, input logic [6:0] a,
        input logic [7:0] d, output logic [7:0] r);
        int n;
        wr(`IDX_MA_ADDR, {1'b0, a});
        wr(`IDX_MA_DATA, d);
        wr(`IDX_MA_CMD, cmd);
        for (n = 0; n < 32; n++)
        begin
            rdr(`IDX_STATUS, r);
            if (r[`BIT_MA_BUSY] === 1'b0)
                break;
        end
        if (n == 32)
            hang();
        rdr(`IDX_MA_DATA, r);
    endtask

    task automatic t_reset();
        logic [7:0] v;
        rdr(`IDX_CTRL, v);
        chk(v, `RST_BYTE);
        rdr(`IDX_IRQ, v);
        chk(v, `RST_BYTE);
        wr(4'hC, 8'hFF);
        rdr(4'hC, v);
        chk(v, 8'h00);
    endtask

    task automatic t_mem();
        logic [7:0] v;
        logic f;
        mem_cmd(`CMD_SET_UCHAN, 7'h0F, 8'hFF, v);
        mem_cmd(`CMD_RD_CODE, 7'h0F, 8'h00, v);
        chk({4'h0, v[3:0]}, 8'h09);
        u_line_side_model.put(1'b1, 7'h0F, 8'hA5);
        mem_cmd(`CMD_RD_DATA, 7'h0F, 8'h00, v);
        chk(v, 8'hA5);
        u_line_side_model.put(1'b1, 7'h0F, 8'h3C);
        mem_cmd(`CMD_RD_DATA, 7'h0F, 8'h00, v);
        chk(v, 8'h3C);
        mem_cmd(`CMD_WR_DATA, 7'h0F, 8'h77, v);
        mem_cmd(`CMD_RD_DATA, 7'h0F, 8'h00, v);
        chk(v, 8'h77);
        mem_cmd(`CMD_RD_CODE, 7'h0F, 8'h00, v);
        chk({4'h0, v[3:0]}, 8'h09);
        mem_cmd(`CMD_CANCEL, 7'h0F, 8'hFF, v);
        mem_cmd(`CMD_RD_CODE, 7'h0F, 8'h00, v);
        chk({4'h0, v[3:0]}, 8'h00);
        u_line_side_model.peek(1'b1, 7'h0F, v, f);
        chk({7'h00, f}, 8'h00);
    endtask

    task automatic t_idle();
        logic [7:0] v;
        logic f;
        mem_cmd(`CMD_SET_UCHAN, 7'h04, 8'h07, v);
        u_line_side_model.peek(1'b1, 7'h04, v, f);
        chk(v, 8'h07);
        chk({7'h00, f}, 8'h01);
    endtask

    task automatic frame_check(input int n, input logic [7:0] exp);
        logic [7:0] s;
        int k;
        int lim;
        lim = (16 * n + 1) * `RCL_CYC;
        u_line_side_model.frame();
        rdr(`IDX_STATUS, s);
        chk({7'h00, s[`BIT_WIN_OPEN]}, 8'h00);
        for (k = 0; k < 3000; k++)
        begin
            rdr(`IDX_STATUS, s);
            if (s[`BIT_WIN_OPEN] === 1'b1)
                break;
        end
        if (k == 3000)
            hang();
        k = cyc - t0;
        n_checks++;
        if (k < lim || k > lim + 16)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, k, lim);
        end
        rdr(`IDX_IRQ, s);
        chk(s, exp);
        rdr(`IDX_IRQ, s);
        chk(s, 8'h00);
    endtask

    task automatic t_sync();
        logic [7:0] v;
        logic f;
        u_line_side_model.put(1'b0, 7'h13, 8'h85);
        u_line_side_model.put(1'b0, 7'h20, 8'h96);
        wr(`IDX_RX_A, 8'h13);
        wr(`IDX_TX_A, 8'h25);
        wr(`IDX_RX_B, 8'h20);
        wr(`IDX_TX_B, 8'h84);
        wr(`IDX_CTRL, 8'hCF);
        frame_check(2, 8'h03);
        // Each frame sends the register first, then captures the source
        u_line_side_model.peek(1'b0, 7'h25, v, f);
        chk({v[7:6], 6'h00}, 8'h00);
        rdr(`IDX_DATA_B, v);
        chk(v, 8'h96);
        wr(`IDX_DATA_A, 8'h55);
        frame_check(2, 8'h02);
        u_line_side_model.peek(1'b0, 7'h25, v, f);
        chk({v[7:6], 6'h00}, 8'h40);
        u_line_side_model.peek(1'b1, 7'h04, v, f);
        chk(v, 8'h96);
        frame_check(2, 8'h03);
        u_line_side_model.peek(1'b0, 7'h25, v, f);
        chk({v[7:6], 6'h00}, 8'h80);
        u_line_side_model.put(1'b0, 7'h13, 8'h4A);
        wr(`IDX_CTRL, 8'h42);
        frame_check(1, 8'h03);
        u_line_side_model.peek(1'b0, 7'h25, v, f);
        chk({4'h0, v[3:0]}, 8'h05);
        rdr(`IDX_DATA_A, v);
        chk(v, 8'h9A);
    endtask

    initial
    begin
        rst_n = 1'b0;
        read = 1'b0;
        write = 1'b0;
        address = 6'h00;
        writedata = 32'h00000000;
        byteenable = 4'hF;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_mem();
        t_idle();
        t_sync();
        complete_run();
    end
endmodule
